// ==== core/dcsp_top.sv ====
// dcsp_top: display configuration, split screen, line addressing, panning
// assumes line and frame strobes from the display timing block, one clock
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "dcsp_map.svh"
module dcsp_top (
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic [7:0]               o_rdata,
    input  wire logic                i_frame_start,
    input  wire logic                i_line_start,
    input  wire logic [9:0]          i_vdisp_lines,
    input  wire logic                i_tft,
    output dcsp_pkg::dcsp_addr_t     o_line_addr,
    output logic                     o_line_valid,
    output logic                     o_screen2,
    output logic [3:0]               o_pan,
    output logic                     o_crt_line_en,
    output logic                     o_lcd_line_en,
    output logic                     o_lcd_line_pulse,
    output logic [4:0]               o_bpp,
    output logic                     o_lut_bypass,
    output logic [4:0]               o_lcd_depth,
    output logic                     o_crt_sig_en,
    output logic                     o_lcd_power,
    output logic                     o_lcd_sig_en
);
    import dcsp_pkg::*;
    dcsp_cfg_if cfg ();
    dcsp_regs u_regs (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_addr  (i_addr),
        .i_wdata (i_wdata),
        .i_wr    (i_wr),
        .cfg     (cfg)
    );
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [4:0] bpp_of(input logic [2:0] code);
        case (code)
            3'h0:    bpp_of = 5'd1;
            3'h1:    bpp_of = 5'd2;
            3'h2:    bpp_of = 5'd4;
            3'h3:    bpp_of = 5'd8;
            3'h4:    bpp_of = 5'd15;
            3'h5:    bpp_of = 5'd16;
            default: bpp_of = 5'd0;
        endcase
    endfunction
    // wider depths keep no sub-word pan, so the field is masked to zero
    function automatic logic [3:0] pan_mask(input logic [2:0] code);
        case (code)
            3'h0:    pan_mask = 4'hf;
            3'h1:    pan_mask = 4'h7;
            3'h2:    pan_mask = 4'h3;
            default: pan_mask = 4'h0;
        endcase
    endfunction
    logic [2:0] bpp_code;
    dcsp_opt_e  opt;
    logic       bypass;
    assign bpp_code = cfg.mode[`DCSP_MODE_BPP_LSB +: 3];
    assign opt      = dcsp_opt_e'(cfg.mode[`DCSP_MODE_OPT_LSB +: 2]);
    assign bypass   = (bpp_code == 3'h4) || (bpp_code == 3'h5);
    // ----------------------------------------
    // static mode outputs
    // ----------------------------------------
    logic [4:0] bpp_reg,   bpp_next;
    logic       byp_reg,   byp_next;
    logic [4:0] depth_reg, depth_next;
    logic       crt_reg,   crt_next;
    always_comb begin
        bpp_next   = bpp_of(bpp_code);
        byp_next   = bypass;
        depth_next = (bypass && !i_tft) ? 5'd12 : bpp_of(bpp_code);
        crt_next   = cfg.mode[`DCSP_MODE_CRT_BIT] && !bypass;
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bpp_reg   <= 5'd0;
            byp_reg   <= 1'b0;
            depth_reg <= 5'd0;
            crt_reg   <= 1'b0;
        end else begin
            bpp_reg   <= bpp_next;
            byp_reg   <= byp_next;
            depth_reg <= depth_next;
            crt_reg   <= crt_next;
        end
    end
    // ----------------------------------------
    // LCD power sequencing
    // ----------------------------------------
    dcsp_pwr_e  pwr_reg,   pwr_next;
    logic       lcd_q_reg, lcd_q_next;
    logic [2:0] pcnt_reg,  pcnt_next;
    logic       lcd_en;
    assign lcd_en = cfg.mode[`DCSP_MODE_LCD_BIT];
    always_comb begin
        pwr_next   = pwr_reg;
        lcd_q_next = lcd_en;
        pcnt_next  = pcnt_reg;
        if (i_frame_start && pcnt_reg != 3'h0) begin
            pcnt_next = pcnt_reg - 3'h1;
        end
        if (lcd_en && !lcd_q_reg) begin
            pwr_next  = DCSP_PWR_UP;
            pcnt_next = `DCSP_PWR_FRAMES;
        end else if (!lcd_en && lcd_q_reg) begin
            pwr_next  = DCSP_PWR_DOWN;
            pcnt_next = `DCSP_PWR_FRAMES;
        end else begin
            case (pwr_reg)
                DCSP_PWR_UP:   if (pcnt_reg == 3'h0) pwr_next = DCSP_PWR_ON;
                DCSP_PWR_DOWN: if (pcnt_reg == 3'h0) pwr_next = DCSP_PWR_OFF;
                default:       pwr_next = pwr_reg;
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pwr_reg   <= DCSP_PWR_OFF;
            lcd_q_reg <= 1'b0;
            pcnt_reg  <= 3'h0;
        end else begin
            pwr_reg   <= pwr_next;
            lcd_q_reg <= lcd_q_next;
            pcnt_reg  <= pcnt_next;
        end
    end
    // ----------------------------------------
    // frame shadow and line addressing
    // ----------------------------------------
    // shadows stop a mid-frame write from tearing the split or the pan
    logic [9:0]  cmp_sh_reg,  cmp_sh_next;
    dcsp_addr_t  s2_sh_reg,   s2_sh_next;
    logic [7:0]  pan_sh_reg,  pan_sh_next;
    logic        odd_reg,     odd_next;
    logic [10:0] cline_reg,   cline_next;
    logic [9:0]  row_reg,     row_next;
    dcsp_addr_t  addr_reg,    addr_next;
    logic        scr2_reg,    scr2_next;
    dcsp_addr_t  oaddr_reg,   oaddr_next;
    logic        ovld_reg,    ovld_next;
    logic        oscr2_reg,   oscr2_next;
    logic [3:0]  opan_reg,    opan_next;
    logic        ocrt_reg,    ocrt_next;
    logic        olcd_reg,    olcd_next;
    logic        opls_reg,    opls_next;
    logic        adv;
    logic        lcd_take;
    always_comb begin
        cmp_sh_next = cmp_sh_reg;
        s2_sh_next  = s2_sh_reg;
        pan_sh_next = pan_sh_reg;
        odd_next    = odd_reg;
        cline_next  = cline_reg;
        row_next    = row_reg;
        addr_next   = addr_reg;
        scr2_next   = scr2_reg;
        oaddr_next  = oaddr_reg;
        oscr2_next  = oscr2_reg;
        opan_next   = opan_reg;
        ocrt_next   = 1'b0;
        olcd_next   = 1'b0;
        opls_next   = 1'b0;
        ovld_next   = 1'b0;
        adv         = (opt != DCSP_OPT_DOUBLE) || cline_reg[0];
        case (opt)
            DCSP_OPT_NORMAL: lcd_take = 1'b1;
            DCSP_OPT_DOUBLE: lcd_take = 1'b1;
            DCSP_OPT_ILACE:  lcd_take = cline_reg[0] ^ odd_reg;
            DCSP_OPT_EVEN:   lcd_take = cline_reg[0];
            default:         lcd_take = 1'b1;
        endcase
        if (i_frame_start) begin
            cmp_sh_next = cfg.cmp;
            s2_sh_next  = cfg.s2;
            pan_sh_next = cfg.pan;
            odd_next    = !odd_reg;
            cline_next  = 11'h000;
            row_next    = 10'h000;
            addr_next   = cfg.s1;
            scr2_next   = 1'b0;
        end else if (i_line_start) begin
            oaddr_next = addr_reg;
            oscr2_next = scr2_reg;
            opan_next  = (scr2_reg ? pan_sh_reg[7:4] : pan_sh_reg[3:0])
                         & pan_mask(bpp_code);
            ovld_next  = 1'b1;
            ocrt_next  = crt_reg;
            olcd_next  = lcd_take && (pwr_reg == DCSP_PWR_ON);
            opls_next  = olcd_next && adv;
            cline_next = cline_reg + 11'h001;
            if (adv) begin
                row_next = row_reg + 10'h001;
                if (row_reg == cmp_sh_reg && cmp_sh_reg < i_vdisp_lines) begin
                    addr_next = s2_sh_reg;
                    scr2_next = 1'b1;
                end else begin
                    addr_next = addr_reg + {10'h000, cfg.stride};
                end
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmp_sh_reg <= `DCSP_RST_CMP;
            s2_sh_reg  <= `DCSP_RST_ADDR;
            pan_sh_reg <= `DCSP_RST_PAN;
            odd_reg    <= 1'b0;
            cline_reg  <= 11'h000;
            row_reg    <= 10'h000;
            addr_reg   <= `DCSP_RST_ADDR;
            scr2_reg   <= 1'b0;
            oaddr_reg  <= `DCSP_RST_ADDR;
            ovld_reg   <= 1'b0;
            oscr2_reg  <= 1'b0;
            opan_reg   <= 4'h0;
            ocrt_reg   <= 1'b0;
            olcd_reg   <= 1'b0;
            opls_reg   <= 1'b0;
        end else begin
            cmp_sh_reg <= cmp_sh_next;
            s2_sh_reg  <= s2_sh_next;
            pan_sh_reg <= pan_sh_next;
            odd_reg    <= odd_next;
            cline_reg  <= cline_next;
            row_reg    <= row_next;
            addr_reg   <= addr_next;
            scr2_reg   <= scr2_next;
            oaddr_reg  <= oaddr_next;
            ovld_reg   <= ovld_next;
            oscr2_reg  <= oscr2_next;
            opan_reg   <= opan_next;
            ocrt_reg   <= ocrt_next;
            olcd_reg   <= olcd_next;
            opls_reg   <= opls_next;
        end
    end
    // ----------------------------------------
    // register read port
    // ----------------------------------------
    logic [7:0] rd_reg, rd_next;
    always_comb begin
        rd_next = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `DCSP_OFS_MODE:      rd_next = {1'b0, cfg.mode};
                `DCSP_OFS_CMP_LO:    rd_next = cfg.cmp[7:0];
                `DCSP_OFS_CMP_HI:    rd_next = {6'h00, cfg.cmp[9:8]};
                `DCSP_OFS_S1_0:      rd_next = cfg.s1[7:0];
                `DCSP_OFS_S1_1:      rd_next = cfg.s1[15:8];
                `DCSP_OFS_S1_2:      rd_next = {4'h0, cfg.s1[19:16]};
                `DCSP_OFS_S2_0:      rd_next = cfg.s2[7:0];
                `DCSP_OFS_S2_1:      rd_next = cfg.s2[15:8];
                `DCSP_OFS_S2_2:      rd_next = {4'h0, cfg.s2[19:16]};
                `DCSP_OFS_STRIDE_LO: rd_next = cfg.stride[7:0];
                `DCSP_OFS_STRIDE_HI: rd_next = {6'h00, cfg.stride[9:8]};
                `DCSP_OFS_PAN:       rd_next = cfg.pan;
                `DCSP_OFS_STATUS:    rd_next = {4'h0, scr2_reg, odd_reg, pwr_reg};
                default:             rd_next = 8'h00;
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_reg <= 8'h00;
        end else begin
            rd_reg <= rd_next;
        end
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rdata          = rd_reg;
    assign o_line_addr      = oaddr_reg;
    assign o_line_valid     = ovld_reg;
    assign o_screen2        = oscr2_reg;
    assign o_pan            = opan_reg;
    assign o_crt_line_en    = ocrt_reg;
    assign o_lcd_line_en    = olcd_reg;
    assign o_lcd_line_pulse = opls_reg;
    assign o_bpp            = bpp_reg;
    assign o_lut_bypass     = byp_reg;
    assign o_lcd_depth      = depth_reg;
    assign o_crt_sig_en     = crt_reg;
    assign o_lcd_power      = (pwr_reg != DCSP_PWR_OFF);
    assign o_lcd_sig_en     = (pwr_reg == DCSP_PWR_ON);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    AST_ADDR_STEP: assert property (
        i_line_start && !i_frame_start && adv && !(row_reg == cmp_sh_reg
            && cmp_sh_reg < i_vdisp_lines)
        |=> addr_reg == $past(addr_reg) + {10'h000, $past(cfg.stride)})
        else $error("line address did not advance by the offset");
    AST_SPLIT: assert property (
        i_line_start && !i_frame_start && adv && row_reg == cmp_sh_reg
            && cmp_sh_reg < i_vdisp_lines
        |=> scr2_reg && addr_reg == $past(s2_sh_reg))
        else $error("screen 2 not entered at line compare");
    AST_NO_SPLIT: assert property (
        cmp_sh_reg >= i_vdisp_lines && $stable(i_vdisp_lines) |=> !$rose(scr2_reg))
        else $error("screen 2 shown with compare not below height");
    AST_FRAME_START: assert property (
        i_frame_start |=> addr_reg == $past(cfg.s1) && !scr2_reg && row_reg == 10'h000)
        else $error("frame did not restart at screen 1 address");
    AST_DOUBLE: assert property (
        o_lcd_line_en && opt == DCSP_OPT_DOUBLE && $stable(opt)
            && !$past(cline_reg[0]) |-> !o_lcd_line_pulse)
        else $error("line pulse on first copy of doubled line");
    AST_EVEN_ONLY: assert property (
        i_line_start && !i_frame_start && opt == DCSP_OPT_EVEN && !cline_reg[0]
        |=> !o_lcd_line_en ##0 o_line_valid)
        else $error("odd scan line sent to LCD in even scan mode");
    AST_PAN_MASK: assert property (
        o_line_valid && $past(bpp_code) == 3'h2 |-> o_pan[3:2] == 2'h0)
        else $error("pan bits above depth limit used");
    AST_BPP: assert property (
        bpp_code == 3'h5 ##1 bpp_code == 3'h5 |-> o_bpp == 5'd16)
        else $error("16 bpp code not decoded");
    AST_CRT_OFF_HI: assert property (
        bypass ##1 bypass |-> !o_crt_sig_en ##1 !o_crt_sig_en || !bypass)
        else $error("CRT enabled in 15/16 bpp mode");
    AST_PWR_ON: assert property (
        lcd_en && !lcd_q_reg |=> pwr_reg == DCSP_PWR_UP && pcnt_reg == `DCSP_PWR_FRAMES)
        else $error("power-on sequence not started");
    AST_PWR_OFF: assert property (
        !lcd_en && lcd_q_reg |=> o_lcd_power && !o_lcd_sig_en)
        else $error("power-off sequence not started");
    COV_SPLIT:  cover property (i_line_start && adv && row_reg == cmp_sh_reg
                                && cmp_sh_reg < i_vdisp_lines);
    COV_DOUBLE: cover property (o_lcd_line_pulse && opt == DCSP_OPT_DOUBLE);
    COV_ILACE:  cover property (o_lcd_line_en && opt == DCSP_OPT_ILACE && odd_reg);
    COV_PWRON:  cover property (pwr_reg == DCSP_PWR_UP ##1 pwr_reg == DCSP_PWR_ON);
endmodule

// ==== core/dcsp_map.svh ====
// dcsp_map.svh: register offsets, field positions, reset values and counts
// assumes an 8-bit register port at the printed byte offsets
`ifndef DCSP_MAP_SVH
`define DCSP_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCSP_OFS_MODE      8'h0d
`define DCSP_OFS_CMP_LO     8'h0e
`define DCSP_OFS_CMP_HI     8'h0f
`define DCSP_OFS_S1_0       8'h10
`define DCSP_OFS_S1_1       8'h11
`define DCSP_OFS_S1_2       8'h12
`define DCSP_OFS_S2_0       8'h13
`define DCSP_OFS_S2_1       8'h14
`define DCSP_OFS_S2_2       8'h15
`define DCSP_OFS_STRIDE_LO  8'h16
`define DCSP_OFS_STRIDE_HI  8'h17
`define DCSP_OFS_PAN        8'h18
`define DCSP_OFS_STATUS     8'h20

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define DCSP_MODE_LCD_BIT   0
`define DCSP_MODE_CRT_BIT   1
`define DCSP_MODE_BPP_LSB   2
`define DCSP_MODE_OPT_LSB   5

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCSP_RST_MODE       7'h00
`define DCSP_RST_CMP        10'h3ff
`define DCSP_RST_ADDR       20'h0_0000
`define DCSP_RST_STRIDE     10'h000
`define DCSP_RST_PAN        8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define DCSP_PWR_FRAMES     3'h4

`endif

// ==== core/dcsp_pkg.sv ====
// dcsp_pkg: types shared by the display configuration block
// assumes dcsp_map.svh is on the include path
package dcsp_pkg;

    typedef enum logic [1:0] {
        DCSP_OPT_NORMAL = 2'h0,
        DCSP_OPT_DOUBLE = 2'h1,
        DCSP_OPT_ILACE  = 2'h2,
        DCSP_OPT_EVEN   = 2'h3
    } dcsp_opt_e;

    // gray sequence off -> up -> on -> down -> off
    typedef enum logic [1:0] {
        DCSP_PWR_OFF  = 2'h0,
        DCSP_PWR_UP   = 2'h1,
        DCSP_PWR_ON   = 2'h3,
        DCSP_PWR_DOWN = 2'h2
    } dcsp_pwr_e;

    typedef logic [19:0] dcsp_addr_t;

endpackage

// ==== core/dcsp_cfg_if.sv ====
// dcsp_cfg_if: programmed configuration from the register store to the core
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface dcsp_cfg_if;
    import dcsp_pkg::*;
    logic [6:0]  mode;
    logic [9:0]  cmp;
    dcsp_addr_t  s1;
    dcsp_addr_t  s2;
    logic [9:0]  stride;
    logic [7:0]  pan;

    modport store (output mode, output cmp, output s1, output s2,
                   output stride, output pan);
    modport core  (input mode, input cmp, input s1, input s2,
                   input stride, input pan);
endinterface

// ==== core/dcsp_regs.sv ====
// dcsp_regs: writable configuration registers of the display block
// assumes single-cycle write strobes from the top-level register port
`timescale 1ns/1ps
`include "dcsp_map.svh"
module dcsp_regs (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    dcsp_cfg_if.store       cfg
);
    import dcsp_pkg::*;

    logic [6:0] mode_reg,   mode_next;
    logic [9:0] cmp_reg,    cmp_next;
    dcsp_addr_t s1_reg,     s1_next;
    dcsp_addr_t s2_reg,     s2_next;
    logic [9:0] stride_reg, stride_next;
    logic [7:0] pan_reg,    pan_next;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    always_comb begin
        mode_next   = mode_reg;
        cmp_next    = cmp_reg;
        s1_next     = s1_reg;
        s2_next     = s2_reg;
        stride_next = stride_reg;
        pan_next    = pan_reg;
        if (i_wr) begin
            case (i_addr)
                `DCSP_OFS_MODE:      mode_next         = i_wdata[6:0];
                `DCSP_OFS_CMP_LO:    cmp_next[7:0]     = i_wdata;
                `DCSP_OFS_CMP_HI:    cmp_next[9:8]     = i_wdata[1:0];
                `DCSP_OFS_S1_0:      s1_next[7:0]      = i_wdata;
                `DCSP_OFS_S1_1:      s1_next[15:8]     = i_wdata;
                `DCSP_OFS_S1_2:      s1_next[19:16]    = i_wdata[3:0];
                `DCSP_OFS_S2_0:      s2_next[7:0]      = i_wdata;
                `DCSP_OFS_S2_1:      s2_next[15:8]     = i_wdata;
                `DCSP_OFS_S2_2:      s2_next[19:16]    = i_wdata[3:0];
                `DCSP_OFS_STRIDE_LO: stride_next[7:0]  = i_wdata;
                `DCSP_OFS_STRIDE_HI: stride_next[9:8]  = i_wdata[1:0];
                `DCSP_OFS_PAN:       pan_next          = i_wdata;
                default:             mode_next         = mode_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg   <= `DCSP_RST_MODE;
            cmp_reg    <= `DCSP_RST_CMP;
            s1_reg     <= `DCSP_RST_ADDR;
            s2_reg     <= `DCSP_RST_ADDR;
            stride_reg <= `DCSP_RST_STRIDE;
            pan_reg    <= `DCSP_RST_PAN;
        end else begin
            mode_reg   <= mode_next;
            cmp_reg    <= cmp_next;
            s1_reg     <= s1_next;
            s2_reg     <= s2_next;
            stride_reg <= stride_next;
            pan_reg    <= pan_next;
        end
    end

    assign cfg.mode   = mode_reg;
    assign cfg.cmp    = cmp_reg;
    assign cfg.s1     = s1_reg;
    assign cfg.s2     = s2_reg;
    assign cfg.stride = stride_reg;
    assign cfg.pan    = pan_reg;

endmodule

// ==== tb/dcsp_tb_disp.sv ====
// dcsp_tb_disp: display timing source, frame and line strobes
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module dcsp_tb_disp (
    input  wire logic i_clk,
    output logic      o_frame_start,
    output logic      o_line_start
);
    // ----------------------------------------
    // one-cycle strobes, never together
    // ----------------------------------------
    // frames sent since reset; the first one after reset is an odd frame
    int n_frames = 0;
    initial begin
        o_frame_start = 1'b0;
        o_line_start  = 1'b0;
    end
    task automatic frame();
        n_frames++;
        @(posedge i_clk);
        o_frame_start <= 1'b1;
        @(posedge i_clk);
        o_frame_start <= 1'b0;
        // gap keeps the first line clear of the restart
        @(posedge i_clk);
    endtask
    task automatic line();
        @(posedge i_clk);
        o_line_start <= 1'b1;
        @(posedge i_clk);
        o_line_start <= 1'b0;
        #1;
    endtask
endmodule

// ==== tb/testbench.sv ====
// testbench: register port, line addressing, split, pan, depth, power
// assumes dcsp_top with the register map of dcsp_map.svh
`timescale 1ns/1ps
`include "dcsp_map.svh"
module testbench;
    import dcsp_pkg::*;
    logic       clk, rstn, wr, rd, tft, fs, ls, lv, s2, crt_en, lcd_en, lpul, byp, cen, pwr, sen;
    logic [7:0] addr, wdata, rdata;
    logic [9:0] vdisp;
    logic [3:0] pan;
    logic [4:0] bpp, depth;
    dcsp_addr_t la;
    int         err_total, n_tests;
    dcsp_top i_dut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_frame_start(fs), .i_line_start(ls),
        .i_vdisp_lines(vdisp), .i_tft(tft), .o_line_addr(la), .o_line_valid(lv),
        .o_screen2(s2), .o_pan(pan), .o_crt_line_en(crt_en), .o_lcd_line_en(lcd_en),
        .o_lcd_line_pulse(lpul), .o_bpp(bpp), .o_lut_bypass(byp), .o_lcd_depth(depth),
        .o_crt_sig_en(cen), .o_lcd_power(pwr), .o_lcd_sig_en(sen));
    dcsp_tb_disp i_disp (.i_clk(clk), .o_frame_start(fs), .o_line_start(ls));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", {12'h000, rdata}, {12'h000, exp});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rchk(`DCSP_OFS_CMP_LO, 8'hff);
        rchk(`DCSP_OFS_CMP_HI, 8'h03);
        wreg(`DCSP_OFS_PAN, 8'h21);
        rchk(`DCSP_OFS_PAN, 8'h21);
        wreg(8'h30, 8'h5a);
        rchk(8'h30, 8'h00);
    endtask
    task automatic t_lines();
        wreg(`DCSP_OFS_MODE, 8'h02);
        wreg(`DCSP_OFS_S1_0, 8'h45); wreg(`DCSP_OFS_S1_1, 8'h23); wreg(`DCSP_OFS_S1_2, 8'h01);
        wreg(`DCSP_OFS_S2_0, 8'h00); wreg(`DCSP_OFS_S2_1, 8'h01); wreg(`DCSP_OFS_S2_2, 8'h00);
        wreg(`DCSP_OFS_STRIDE_LO, 8'h50); wreg(`DCSP_OFS_STRIDE_HI, 8'h02);
        wreg(`DCSP_OFS_CMP_LO, 8'h01); wreg(`DCSP_OFS_CMP_HI, 8'h00);
        i_disp.frame();
        i_disp.line();
        chk("valid", lv, 1'b1);
        chk("crt", crt_en, 1'b1);
        chk("addr0", la, 20'h1_2345);
        chk("pan0", pan, 4'h1);
        i_disp.line();
        chk("addr1", la, 20'h1_2595);
        i_disp.line();
        chk("scr2", s2, 1'b1);
        chk("addr2", la, 20'h0_0100);
        chk("pan2", pan, 4'h2);
        i_disp.line();
        chk("addr3", la, 20'h0_0350);
    endtask
    task automatic t_depth();
        logic [4:0] tbl [8] = '{5'd1, 5'd2, 5'd4, 5'd8, 5'd15, 5'd16, 5'd0, 5'd0};
        for (int c = 0; c < 8; c++) begin
            wreg(`DCSP_OFS_MODE, {1'b0, 2'b00, c[2:0], 2'b10});
            repeat (2) @(posedge clk);
            #1 chk("bpp", bpp, tbl[c]);
            chk("byp", byp, (c == 4 || c == 5));
            chk("crt_sig", cen, !(c == 4 || c == 5));
            if (c == 4 || c == 5) chk("depth", depth, 5'd12);
        end
        // a TFT panel takes the full 16 bits, passive panels only 12
        wreg(`DCSP_OFS_MODE, 8'h16);
        tft <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("depth_tft", depth, 5'd16);
        @(posedge clk);
        tft <= 1'b0;
    endtask
    task automatic t_power();
        wreg(`DCSP_OFS_MODE, 8'h03);
        // the power state moves one clock after the enable bit lands
        @(posedge clk);
        #1 chk("pwr_up", {pwr, sen}, 2'b10);
        repeat (4) i_disp.frame();
        #1 chk("pwr_on", {pwr, sen}, 2'b11);
        wreg(`DCSP_OFS_MODE, 8'h02);
        @(posedge clk);
        #1 chk("pwr_dn", {pwr, sen}, 2'b10);
        repeat (4) i_disp.frame();
        #1 chk("pwr_off", {pwr, sen}, 2'b00);
    endtask
    task automatic t_modes();
        logic exp_lcd;
        // single panel, so doubling is legal and the half frame buffer is moot
        wreg(`DCSP_OFS_MODE, 8'h23);
        repeat (4) i_disp.frame();
        i_disp.line();
        chk("dbl_a_addr", la, 20'h1_2345);
        chk("dbl_a_en", {crt_en, lcd_en, lpul}, 3'b110);
        i_disp.line();
        chk("dbl_b_addr", la, 20'h1_2345);
        chk("dbl_b_en", {crt_en, lcd_en, lpul}, 3'b111);
        i_disp.line();
        chk("dbl_c_addr", la, 20'h1_2595);
        chk("dbl_c_pulse", lpul, 1'b0);
        wreg(`DCSP_OFS_MODE, 8'h43);
        for (int f = 0; f < 2; f++) begin
            i_disp.frame();
            exp_lcd = i_disp.n_frames[0];
            i_disp.line();
            chk("ilace_0", {crt_en, lcd_en}, {1'b1, exp_lcd});
            i_disp.line();
            chk("ilace_1", {crt_en, lcd_en}, {1'b1, !exp_lcd});
        end
        wreg(`DCSP_OFS_PAN, 8'hff);
        wreg(`DCSP_OFS_MODE, 8'h6b);
        i_disp.frame();
        i_disp.line();
        chk("even_0", {lv, crt_en, lcd_en}, 3'b110);
        chk("pan_4bpp", pan, 4'h3);
        i_disp.line();
        chk("even_1", {lcd_en, lpul}, 2'b11);
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        err_total = 0; n_tests = 0;
        rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
        tft = 1'b0; vdisp = 10'h005;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_lines();
        t_depth();
        t_power();
        t_modes();
        complete_run();
    end
endmodule
